// *** include/gfl_pkg.sv ***
package gfl_pkg;
  // Pin count and widths
  localparam int NUM_PINS = 4;
  localparam int FUNC_W = 5;
  localparam int DB_W = 4;
  // Function select codes
  localparam logic [4:0] FN_FIXED_OUT = 5'h01;
  localparam logic [4:0] FN_BUTTON_IN = 5'h02;
  localparam logic [4:0] FN_IRQ_OUT = 5'h03;
  localparam logic [4:0] FN_TEMP_WARN = 5'h04;
  localparam logic [4:0] FN_TEMP_SHUT = 5'h05;
  localparam logic [4:0] FN_LOOP1_CLK = 5'h15;
  localparam logic [4:0] FN_LOOP2_CLK = 5'h16;
  // De-bounce: stable count in cycles
  localparam int DB_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [3:0] DB_CYCLES =
    4'((DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Register byte offsets
  localparam logic [7:0] PIN_CFG_BASE = 8'h00;
  localparam logic [7:0] THERM_CTRL_OFS = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h18;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h1c;
  localparam logic [7:0] PIN_LEVEL_OFS = 8'h20;
  // Pin config field positions
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_LVL_BIT = 8;
  localparam int CFG_INV_BIT = 9;
  localparam int CFG_DB_BIT = 10;
  // Thermal control bits
  localparam int TH_SENSOR_ON_BIT = 0;
  localparam int TH_CUTOFF_BIT = 1;
  localparam int TH_WARN_DB_BIT = 2;
  localparam int TH_SHUT_DB_BIT = 3;
  // Interrupt bit layout: pins then warn, shut
  localparam int IRQ_W = NUM_PINS + 2;
  localparam int IRQ_WARN_BIT = NUM_PINS;
  localparam int IRQ_SHUT_BIT = NUM_PINS + 1;
  // Reset values
  localparam logic [4:0] FUNC_RST = 5'h02;
  localparam logic [3:0] THERM_RST = 4'h3;
endpackage : gfl_pkg

// *** design/gfl_top.sv ***
// How it works
// [R1] Code 15h drives first loop clock
// [R2] Code 16h drives second loop clock
// [R3] Button input also serves jack detect
// [R4] Software should enable de-bounce for detect
// [R5] Level read shows de-bounced input
// [R6] Level readback ignores invert bit
// [R7] Pin input edges both raise events
// [R8] Status bits latch; feed interrupt request
// [R9] Fixed output drives level bit value
// [R10] Invert bit complements driven level
// [R11] Pin may output combined interrupt
// [R12] Each source maskable before combining
// [R13] Pin may show warning or shutdown
// [R14] Optional de-bounce on temperature signals
// [R15] Temperature edges both raise events
// [R16] Temperature status only when sensor on
// [R17] Overheat with cutoff disables speakers
// [R18] Sensor and cutoff enabled after reset
// [R19] Status stays set until software clears
`timescale 1ns/1ps
`default_nettype none

// Stable-count de-bounce with bypass
module gfl_debounce (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Signal
  input wire logic en_i,
  input wire logic raw_i,
  output logic out_o
);
  typedef struct packed {
    logic stable;
    logic [3:0] cnt;
  } gfl_db_state_t;
  gfl_db_state_t s_q, s_d;

  // Accept new value only after it holds
  always_comb begin
    s_d = s_q;
    if (raw_i == s_q.stable) begin
      s_d.cnt = 4'h0;
    end else if (s_q.cnt >= gfl_pkg::DB_CYCLES - 4'h1) begin
      s_d.stable = raw_i;
      s_d.cnt = 4'h0;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_o = en_i ? raw_i : s_q.stable; // Bypass when en_i is high
endmodule : gfl_debounce

// Two-stage synchroniser for asynchronous levels
module gfl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } gfl_sync_state_t;
  gfl_sync_state_t s_q, s_d;

  // Shift through two stages; only the second is read
  always_comb begin
    s_d.meta = async_i;
    s_d.safe = s_q.meta;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.safe; // Second stage only
endmodule : gfl_sync

// Sticky event bit: either edge sets, software clears
module gfl_sticky (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Event source and clear
  input wire logic lvl_i,
  input wire logic clr_i,
  output logic flag_o
);
  typedef struct packed {
    logic prev;
    logic flag;
  } gfl_sticky_state_t;
  gfl_sticky_state_t s_q, s_d;

  // Set beats a clear in the same cycle
  always_comb begin
    s_d.prev = lvl_i;
    s_d.flag = (s_q.flag & !clr_i) | (lvl_i ^ s_q.prev); // [R7] [R19]
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_o = s_q.flag; // [R8]
endmodule : gfl_sticky

// Output select for one pin
module gfl_pin_drive (
  // Pin configuration
  input wire logic [4:0] func_i,
  input wire logic level_i,
  input wire logic invert_i,
  // Internal sources
  input wire logic irq_i,
  input wire logic warn_i,
  input wire logic shut_i,
  input wire logic loop1_clk_i,
  input wire logic loop2_clk_i,
  // Pin drive
  output logic out_o,
  output logic oe_o
);
  // Pick the source; unknown codes leave the pin floating
  always_comb begin
    out_o = 1'b0;
    oe_o = 1'b1;
    case (func_i)
      gfl_pkg::FN_FIXED_OUT: out_o = level_i ^ invert_i; // [R9] [R10]
      gfl_pkg::FN_BUTTON_IN: oe_o = 1'b0; // [R3]
      gfl_pkg::FN_IRQ_OUT: out_o = irq_i ^ invert_i; // [R11]
      gfl_pkg::FN_TEMP_WARN: out_o = warn_i ^ invert_i; // [R13]
      gfl_pkg::FN_TEMP_SHUT: out_o = shut_i ^ invert_i; // [R13]
      gfl_pkg::FN_LOOP1_CLK: out_o = loop1_clk_i; // [R1]
      gfl_pkg::FN_LOOP2_CLK: out_o = loop2_clk_i; // [R2]
      default: oe_o = 1'b0;
    endcase
  end
endmodule : gfl_pin_drive

module gfl_top (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Pins
  input wire logic [3:0] GPIO_IN_I,
  output logic [3:0] GPIO_OUT_O,
  output logic [3:0] GPIO_OE_O,
  // Clock and sensor sources
  input wire logic FIRST_LOCKED_LOOP_CLK_I,
  input wire logic SECOND_LOCKED_LOOP_CLK_I,
  input wire logic TEMP_WARN_RAW_I,
  input wire logic TEMP_SHUT_RAW_I,
  // Speaker enables and interrupt
  output logic LEFT_SPEAKER_OUT_EN_O,
  output logic RIGHT_SPEAKER_OUT_EN_O,
  output logic IRQ_O
);
  localparam int NP = gfl_pkg::NUM_PINS;
  localparam int IW = gfl_pkg::IRQ_W;

  typedef struct packed {
    logic [NP-1:0][4:0] func;
    logic [NP-1:0] pin_level_bit;
    logic [NP-1:0] pin_invert_bit;
    logic [NP-1:0] pin_db_en;
    logic thermal_sensor_on;
    logic overheat_output_cutoff;
    logic warn_db_en;
    logic shut_db_en;
    logic [IW-1:0] irq_enable;
    logic [31:0] rdata;
    logic [1:0] spk_on;
  } gfl_state_t;
  gfl_state_t s_q, s_d;

  logic [NP-1:0] pin_db;
  logic warn_db, shut_db;
  logic [IW-1:0] cur_lvl;
  logic irq_any;
  logic overheat;
  logic wr_acc, rd_acc;
  logic [7:0] ofs;
  logic [NP-1:0] pin_sync;
  logic [1:0] temp_sync;
  logic [IW-1:0] irq_status;
  logic [IW-1:0] irq_clr;

  // Pin levels cross into the clock domain
  gfl_sync #(
    .W(NP)
  ) u_pin_sync (
    .clk_i(CLOCK_I),
    .rst_ni(RESETN_I),
    .async_i(GPIO_IN_I),
    .sync_o(pin_sync)
  );

  // Sensor levels cross into the clock domain
  gfl_sync #(
    .W(2)
  ) u_temp_sync (
    .clk_i(CLOCK_I),
    .rst_ni(RESETN_I),
    .async_i({TEMP_SHUT_RAW_I, TEMP_WARN_RAW_I}),
    .sync_o(temp_sync)
  );

  // De-bounce per pin input
  for (genvar i = 0; i < NP; i++) begin : g_pin_db
    gfl_debounce u_db (
      .clk_i(CLOCK_I),
      .rst_ni(RESETN_I),
      .en_i(!s_q.pin_db_en[i]),
      .raw_i(pin_sync[i]),
      .out_o(pin_db[i])
    ); // [R3] [R5]
  end

  // De-bounce of temperature status
  gfl_debounce u_warn_db (
    .clk_i(CLOCK_I),
    .rst_ni(RESETN_I),
    .en_i(!s_q.warn_db_en),
    .raw_i(temp_sync[0] & s_q.thermal_sensor_on),
    .out_o(warn_db)
  ); // [R14] [R16]
  gfl_debounce u_shut_db (
    .clk_i(CLOCK_I),
    .rst_ni(RESETN_I),
    .en_i(!s_q.shut_db_en),
    .raw_i(temp_sync[1] & s_q.thermal_sensor_on),
    .out_o(shut_db)
  ); // [R14] [R16]

  // Interrupt source levels
  assign cur_lvl = {shut_db, warn_db, pin_db};
  assign irq_any = |(irq_status & s_q.irq_enable); // [R12]
  assign overheat = shut_db & s_q.thermal_sensor_on;

  // APB decode
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_acc = PSEL_I & !PENABLE_I & !PWRITE_I;
  assign ofs = PADDR_I;

  // Clear strobe per status bit, write-only register
  assign irq_clr = (wr_acc && ofs == gfl_pkg::IRQ_CLEAR_OFS && PSTRB_I[0]) ?
    PWDATA_I[IW-1:0] : {IW{1'b0}}; // [R19]

  // Sticky status bit per source
  for (genvar i = 0; i < IW; i++) begin : g_sticky
    gfl_sticky u_sticky (
      .clk_i(CLOCK_I),
      .rst_ni(RESETN_I),
      .lvl_i(cur_lvl[i]),
      .clr_i(irq_clr[i]),
      .flag_o(irq_status[i])
    ); // [R7] [R8] [R15]
  end

  // Next state
  always_comb begin
    s_d = s_q;
    // Register writes
    if (wr_acc) begin
      for (int i = 0; i < NP; i++) begin
        if (ofs == gfl_pkg::PIN_CFG_BASE + 8'(4 * i)) begin
          if (PSTRB_I[0]) begin
            s_d.func[i] = PWDATA_I[gfl_pkg::CFG_FUNC_LSB +: 5];
          end
          if (PSTRB_I[1]) begin
            s_d.pin_level_bit[i] = PWDATA_I[gfl_pkg::CFG_LVL_BIT];
            s_d.pin_invert_bit[i] = PWDATA_I[gfl_pkg::CFG_INV_BIT];
            s_d.pin_db_en[i] = PWDATA_I[gfl_pkg::CFG_DB_BIT];
          end
        end
      end
      if (ofs == gfl_pkg::THERM_CTRL_OFS && PSTRB_I[0]) begin
        s_d.thermal_sensor_on = PWDATA_I[gfl_pkg::TH_SENSOR_ON_BIT];
        s_d.overheat_output_cutoff = PWDATA_I[gfl_pkg::TH_CUTOFF_BIT];
        s_d.warn_db_en = PWDATA_I[gfl_pkg::TH_WARN_DB_BIT];
        s_d.shut_db_en = PWDATA_I[gfl_pkg::TH_SHUT_DB_BIT];
      end
      if (ofs == gfl_pkg::IRQ_ENABLE_OFS && PSTRB_I[0]) begin
        s_d.irq_enable = PWDATA_I[IW-1:0];
      end
    end
    // Read data captured in setup cycle
    if (rd_acc) begin
      s_d.rdata = 32'h0;
      for (int i = 0; i < NP; i++) begin
        if (ofs == gfl_pkg::PIN_CFG_BASE + 8'(4 * i)) begin
          s_d.rdata[gfl_pkg::CFG_FUNC_LSB +: 5] = s_q.func[i];
          s_d.rdata[gfl_pkg::CFG_LVL_BIT] =
            (s_q.func[i] == gfl_pkg::FN_FIXED_OUT) ?
            s_q.pin_level_bit[i] : pin_db[i]; // [R5] [R6]
          s_d.rdata[gfl_pkg::CFG_INV_BIT] = s_q.pin_invert_bit[i];
          s_d.rdata[gfl_pkg::CFG_DB_BIT] = s_q.pin_db_en[i];
        end
      end
      case (ofs)
        gfl_pkg::THERM_CTRL_OFS: s_d.rdata[3:0] = {s_q.shut_db_en,
          s_q.warn_db_en, s_q.overheat_output_cutoff,
          s_q.thermal_sensor_on};
        gfl_pkg::IRQ_STATUS_OFS: s_d.rdata[IW-1:0] = irq_status; // [R8]
        gfl_pkg::IRQ_ENABLE_OFS: s_d.rdata[IW-1:0] = s_q.irq_enable;
        gfl_pkg::PIN_LEVEL_OFS: s_d.rdata[IW-1:0] = cur_lvl; // [R5]
        default: ;
      endcase
    end
    // Speaker enable: cut on overheat with cutoff set
    s_d.spk_on = {2{!(overheat & s_q.overheat_output_cutoff)}}; // [R17]
  end

  // State register
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
      s_q.func <= {NP{gfl_pkg::FUNC_RST}};
      s_q.thermal_sensor_on <= gfl_pkg::THERM_RST[0]; // [R18]
      s_q.overheat_output_cutoff <= gfl_pkg::THERM_RST[1]; // [R18]
      s_q.spk_on <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // Output select per pin
  for (genvar i = 0; i < NP; i++) begin : g_pin_drive
    gfl_pin_drive u_drive (
      .func_i(s_q.func[i]),
      .level_i(s_q.pin_level_bit[i]),
      .invert_i(s_q.pin_invert_bit[i]),
      .irq_i(irq_any),
      .warn_i(warn_db),
      .shut_i(shut_db),
      .loop1_clk_i(FIRST_LOCKED_LOOP_CLK_I),
      .loop2_clk_i(SECOND_LOCKED_LOOP_CLK_I),
      .out_o(GPIO_OUT_O[i]),
      .oe_o(GPIO_OE_O[i])
    ); // [R1] [R2] [R9] [R10] [R11] [R13]
  end

  // Bus answers and outputs
  assign PRDATA_O = s_q.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign IRQ_O = irq_any; // [R12]
  assign LEFT_SPEAKER_OUT_EN_O = s_q.spk_on[0];
  assign RIGHT_SPEAKER_OUT_EN_O = s_q.spk_on[1];
endmodule : gfl_top
`default_nettype wire

// *** testbench/gfl_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the pin function block
module gfl_top_properties (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // Bus and pins
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [3:0] GPIO_IN_I,
  input wire logic [3:0] GPIO_OE_O,
  input wire logic TEMP_WARN_RAW_I,
  input wire logic TEMP_SHUT_RAW_I,
  input wire logic LEFT_SPEAKER_OUT_EN_O,
  input wire logic RIGHT_SPEAKER_OUT_EN_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // Completed write access
  logic wr;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  // Quiet bus and quiet sources
  sequence s_q;
    $stable({GPIO_IN_I, TEMP_WARN_RAW_I, TEMP_SHUT_RAW_I}) && !PSEL_I;
  endsequence
  property p_irq_fall;
    $fell(IRQ_O) |-> $past(wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  property p_quiet;
    s_q [*8] ##1 s_q [*8] |=> $stable(IRQ_O);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("interrupt moved with no cause");
  property p_spk_pair;
    LEFT_SPEAKER_OUT_EN_O == RIGHT_SPEAKER_OUT_EN_O;
  endproperty
  a_spk_pair: assert property (p_spk_pair)
    else $error("speaker enables differ");
  property p_cool;
    !TEMP_SHUT_RAW_I [*8] ##1 !TEMP_SHUT_RAW_I [*8]
      |-> LEFT_SPEAKER_OUT_EN_O;
  endproperty
  a_cool: assert property (p_cool)
    else $error("speaker off while cool");
  property p_rst_vals;
    $rose(RESETN_I) |-> GPIO_OE_O == 4'h0 && !IRQ_O && LEFT_SPEAKER_OUT_EN_O;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("bad state after reset");
  property p_oe;
    $changed(GPIO_OE_O) |-> $past(wr);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin drive changed without a write");
  property p_rdata;
    $changed(PRDATA_O) |-> $past(PSEL_I && !PENABLE_I && !PWRITE_I);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data changed outside a read");
  property p_ready;
    PREADY_O && !PSLVERR_O;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer not immediate");
  c_irq: cover property ($rose(IRQ_O));
  c_spk: cover property ($fell(LEFT_SPEAKER_OUT_EN_O));
  c_oe: cover property ($rose(GPIO_OE_O[0]));
endmodule : gfl_top_properties
bind gfl_top gfl_top_properties i_props (.CLOCK_I, .RESETN_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .GPIO_IN_I,
  .GPIO_OE_O, .TEMP_WARN_RAW_I, .TEMP_SHUT_RAW_I, .LEFT_SPEAKER_OUT_EN_O,
  .RIGHT_SPEAKER_OUT_EN_O, .IRQ_O);
`default_nettype wire

// *** testbench/gfl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side of the pins
module gfl_host_model (
  // Pin wires
  input wire logic [3:0] oe_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] lvl_i,
  output logic [3:0] pin_o
);
  // Driven pins show the block, others the host
  assign pin_o = (oe_i & out_i) | (~oe_i & lvl_i);
endmodule : gfl_host_model
`default_nettype wire

// *** testbench/test_gpio_function_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_gpio_function_logic;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic c1 = 1'b0, c2 = 1'b0, tw = 1'b0, ts = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, r;
  logic [3:0] hl = 4'h0, gin, gout, goe;
  logic prdy, perr, spl, spr, irq;
  int num_errors = 0, checked = 0, cyc = 0;
  gfl_top i_gfl_top (.CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PSTRB_I(4'hf), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .GPIO_IN_I(gin), .GPIO_OUT_O(gout), .GPIO_OE_O(goe),
    .FIRST_LOCKED_LOOP_CLK_I(c1), .SECOND_LOCKED_LOOP_CLK_I(c2),
    .TEMP_WARN_RAW_I(tw), .TEMP_SHUT_RAW_I(ts),
    .LEFT_SPEAKER_OUT_EN_O(spl), .RIGHT_SPEAKER_OUT_EN_O(spr), .IRQ_O(irq));
  gfl_host_model i_gfl_host_model (.oe_i(goe), .out_i(gout), .lvl_i(hl),
    .pin_o(gin));
  // Clock and hang limit
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  task finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // One bus transfer, setup then access until ready
  task apb(input logic wn, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wn;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task t_reset();
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h3);
    chk(goe, 4'h0);
    chk(spl, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
  endtask : t_reset
  task t_fixed();
    apb(1'b1, 8'h00, 32'h101);
    chk({goe[0], gout[0]}, 2'h3);
    apb(1'b1, 8'h00, 32'h301);
    chk(gout[0], 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h301);
  endtask : t_fixed
  task t_clk();
    apb(1'b1, 8'h04, 32'h15);
    apb(1'b1, 8'h08, 32'h16);
    for (int i = 0; i < 2; i++) begin
      c1 <= i[0];
      c2 <= !i[0];
      w(2);
      chk(gout[1], i[0]);
      chk(gout[2], !i[0]);
    end
  endtask : t_clk
  task t_button();
    apb(1'b1, 8'h0c, 32'h602);
    apb(1'b1, 8'h1c, 32'h8);
    apb(1'b1, 8'h18, 32'h3f);
    hl[3] <= 1'b1;
    w(16);
    chk(irq, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[3], 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk(r[3], 1'b1);
    apb(1'b1, 8'h18, 32'h8);
    chk(irq, 1'b0);
    hl[3] <= 1'b0;
    w(16);
    chk(irq, 1'b1);
    apb(1'b1, 8'h1c, 32'h0);
    chk(irq, 1'b0);
  endtask : t_button
  task t_irqpin();
    apb(1'b1, 8'h1c, 32'h8);
    apb(1'b1, 8'h00, 32'h3);
    chk(gout[0], 1'b1);
    apb(1'b1, 8'h18, 32'h8);
    chk(gout[0], 1'b0);
  endtask : t_irqpin
  task t_temp();
    apb(1'b1, 8'h10, 32'hb);
    apb(1'b1, 8'h1c, 32'h20);
    ts <= 1'b1;
    w(4);
    ts <= 1'b0;
    w(16);
    chk(spl, 1'b1);
    apb(1'b1, 8'h18, 32'h3f);
    ts <= 1'b1;
    w(16);
    chk({spl, spr}, 2'h0);
    chk(irq, 1'b1);
    apb(1'b1, 8'h00, 32'h5);
    chk(gout[0], 1'b1);
    apb(1'b1, 8'h00, 32'h4);
    chk(gout[0], 1'b0);
    tw <= 1'b1;
    w(4);
    chk(gout[0], 1'b1);
    apb(1'b1, 8'h10, 32'h2);
    w(4);
    chk(spl, 1'b1);
    chk(gout[0], 1'b0);
  endtask : t_temp
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_fixed();
    t_clk();
    t_button();
    t_irqpin();
    t_temp();
    finish_test();
  end
endmodule : test_gpio_function_logic
`default_nettype wire
